// File: rtl/tx_crc_and_rx_rate_config.v
// Transmit checksum generator, receive rate setting and their register slave
`timescale 1ns/100ps
`default_nettype none
`include "tx_crc_cfg_regs.vh"

// ----------------------------------------
// Byte FIFO
// ----------------------------------------
module tx_byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = ce & (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// Contract
// - Software holds a 16-bit custom seed in bits 31:16 of checksum control.
// - Skip bit set leaves the first frame byte out of the checksum.
// - Seed codes 0 to 5 load 0000h, 6363h, A671h, FFFFh, 0012h, E012h.
// - Seed code 7 loads the custom seed; code 6 is reserved.
// - For the 5-bit checksum only the seed's low byte is applied.
// - Width bit 0 selects 16-bit checksum, 1 selects 5-bit; reset 0.
// - Invert bit sends the complemented checksum; reset 0 sends it unchanged.
// - Append bit 1 computes and sends a checksum; 0 sends none.
// - Rate field codes 4 to 7 give 106, 212, 424, 848 kBd; reset 0.
// - Rate field top bit matters only in reader mode, ignored in card mode.
// - With auto detection on, a detected mode overwrites the rate field.
// - Detected type A or B peer writes rate code 100.
// - Detected type F 212 or 424 writes rate code 101 or 110.
module tx_crc_and_rx_rate_config #(
  parameter ADDR_W = 10,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire SYS_CLK,
  input wire RSTN,
  input wire CE,
  input wire [ADDR_W-1:0] S_AXI_AWADDR,
  input wire [2:0] S_AXI_AWPROT,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [ADDR_W-1:0] S_AXI_ARADDR,
  input wire [2:0] S_AXI_ARPROT,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [7:0] TX_DATA,
  input wire TX_LAST,
  input wire TX_VALID,
  output wire TX_READY,
  output wire TX_BIT,
  output wire TX_BIT_VALID,
  output wire TX_BIT_LAST,
  input wire TX_BIT_READY,
  input wire MODE_DETECTED,
  input wire [1:0] MODE_KIND,
  output wire [2:0] RX_RATE
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_CRC = 2'h3;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] crc_seed;
  reg crc_skip_first_byte;
  reg [2:0] crc_seed_sel;
  reg crc_type5;
  reg crc_invert_output;
  reg crc_enable;
  reg [2:0] rx_symbol_rate;
  reg auto_detect_en;
  reg reader_mode;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  reg aw_full;
  reg [ADDR_W-1:0] aw_addr;
  reg w_full;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  wire wr_ctl;
  wire wr_rate;
  wire wr_det;
  wire [31:0] ctl_word;
  wire [31:0] rate_word;
  wire [31:0] det_word;
  wire busy;

  // Readies drop with CE so no transfer is lost while frozen
  assign S_AXI_AWREADY = CE & ~aw_full;
  assign S_AXI_WREADY = CE & ~w_full;
  assign S_AXI_ARREADY = CE & ~S_AXI_RVALID;
  // Write completes only once both halves are in and no response is pending
  assign do_write = CE & aw_full & w_full & ~S_AXI_BVALID;
  assign wr_ctl = do_write && (aw_addr == `ADDR_TX_CHECKSUM_CONTROL);
  assign wr_rate = do_write && (aw_addr == `ADDR_RX_SIGPRO_SETUP);
  assign wr_det = do_write && (aw_addr == `ADDR_DETECTOR_CONTROL);

  assign ctl_word = {crc_seed, 9'h000, crc_skip_first_byte, crc_seed_sel, crc_type5,
    crc_invert_output, crc_enable};
  assign rate_word = {29'h00000000, rx_symbol_rate};
  assign det_word = {29'h00000000, busy, reader_mode, auto_detect_en};

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_full <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= 2'h0;
      S_AXI_RDATA <= 32'h00000000;
    end else if (CE) begin
      if (S_AXI_AWVALID && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_full) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wr_ctl | wr_rate | wr_det) ? 2'h0 : 2'h2;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (S_AXI_ARVALID && !S_AXI_RVALID) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= 2'h0;
        case (S_AXI_ARADDR)
          `ADDR_TX_CHECKSUM_CONTROL: begin
            S_AXI_RDATA <= ctl_word;
          end
          `ADDR_RX_SIGPRO_SETUP: begin
            S_AXI_RDATA <= rate_word;
          end
          `ADDR_DETECTOR_CONTROL: begin
            S_AXI_RDATA <= det_word;
          end
          default: begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'h2;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register writes and rate overwrite
  // ----------------------------------------
  reg [2:0] detected_rate;

  always @* begin
    case (MODE_KIND)
      `DET_TYPE_AB: detected_rate = `RATE_106;
      `DET_F212: detected_rate = `RATE_212;
      `DET_F424: detected_rate = `RATE_424;
      default: detected_rate = rx_symbol_rate;
    endcase
  end

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      crc_seed <= 16'h0000;
      crc_skip_first_byte <= 1'b0;
      crc_seed_sel <= `SEED_SEL_0000;
      crc_type5 <= 1'b0;
      crc_invert_output <= 1'b0;
      crc_enable <= 1'b0;
      rx_symbol_rate <= `RATE_RESET;
      auto_detect_en <= 1'b0;
      reader_mode <= 1'b0;
    end else if (CE) begin
      if (wr_ctl) begin
        if (w_strb[3]) crc_seed[15:8] <= w_data[31:24];
        if (w_strb[2]) crc_seed[7:0] <= w_data[23:16];
        if (w_strb[0]) begin
          crc_skip_first_byte <= w_data[`CRC_SKIP_BIT];
          crc_seed_sel <= w_data[`CRC_SEL_HI:`CRC_SEL_LO];
          crc_type5 <= w_data[`CRC_TYPE_BIT];
          crc_invert_output <= w_data[`CRC_INV_BIT];
          crc_enable <= w_data[`CRC_EN_BIT];
        end
      end
      // Detector wins over a software write in the same cycle
      if (auto_detect_en && MODE_DETECTED && (MODE_KIND != 2'h3)) begin
        rx_symbol_rate <= detected_rate;
      end else if (wr_rate && w_strb[0]) begin
        rx_symbol_rate <= w_data[`RATE_HI:`RATE_LO];
      end
      if (wr_det && w_strb[0]) begin
        auto_detect_en <= w_data[`DETCTL_AUTO_BIT];
        reader_mode <= w_data[`DETCTL_READER_BIT];
      end
    end
  end

  // Card mode treats the top bit as set, so only 106 to 848 kBd result
  assign RX_RATE = reader_mode ? rx_symbol_rate : {1'b1, rx_symbol_rate[1:0]};

  // ----------------------------------------
  // Seed selection
  // ----------------------------------------
  reg [15:0] fixed_seed;
  wire [15:0] start_value;

  always @* begin
    case (crc_seed_sel)
      `SEED_SEL_0000: fixed_seed = `SEED_0;
      `SEED_SEL_6363: fixed_seed = `SEED_1;
      `SEED_SEL_A671: fixed_seed = `SEED_2;
      `SEED_SEL_FFFF: fixed_seed = `SEED_3;
      `SEED_SEL_0012: fixed_seed = `SEED_4;
      `SEED_SEL_E012: fixed_seed = `SEED_5;
      `SEED_SEL_CUSTOM: fixed_seed = crc_seed;
      default: fixed_seed = `SEED_0;
    endcase
  end

  assign start_value = crc_type5 ? {8'h00, fixed_seed[7:0]} : fixed_seed;

  // ----------------------------------------
  // Checksum step, least significant bit first
  // ----------------------------------------
  function [15:0] crc_step;
    input [15:0] crc;
    input bit_in;
    input short;
    reg fb16;
    reg fb5;
    begin
      fb16 = crc[0] ^ bit_in;
      fb5 = crc[0] ^ bit_in;
      if (short) begin
        crc_step = {11'h000, {1'b0, crc[4:1]} ^ (fb5 ? `POLY5_REFL : 5'h00)};
      end else begin
        crc_step = {1'b0, crc[15:1]} ^ (fb16 ? `POLY16_REFL : 16'h0000);
      end
    end
  endfunction

  // ----------------------------------------
  // Transmit serializer
  // ----------------------------------------
  wire [8:0] fifo_out;
  wire fifo_valid;
  wire fifo_pop;
  reg [1:0] state;
  reg [15:0] shreg;
  reg [4:0] bit_cnt;
  reg [15:0] crc;
  reg first_byte;
  reg byte_last;
  reg frame_crc_en;
  reg frame_inv;
  reg frame_type5;
  reg frame_skip;
  wire frame_skip_active;
  wire bit_take;
  wire crc_hold;
  wire [15:0] crc_next;
  wire [15:0] crc_out;
  wire [4:0] crc_len;

  // Popping stalls while the encoder is busy, so the FIFO backs up to TX_READY
  tx_byte_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .ce(CE),
    .in_data({TX_LAST, TX_DATA}),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  assign fifo_pop = (state == ST_LOAD);
  assign busy = (state != ST_IDLE);
  assign bit_take = CE & TX_BIT_READY & ((state == ST_DATA) | (state == ST_CRC));
  assign crc_hold = frame_skip_active;
  assign crc_next = crc_hold ? crc : crc_step(crc, shreg[0], frame_type5);
  assign crc_out = frame_inv ? ~crc_next : crc_next;
  assign crc_len = frame_type5 ? `CRC5_LEN : `CRC16_LEN;
  assign TX_BIT = shreg[0];
  assign TX_BIT_VALID = (state == ST_DATA) | (state == ST_CRC);
  assign TX_BIT_LAST = ((state == ST_CRC) && (bit_cnt == crc_len - 5'h01)) ||
    ((state == ST_DATA) && byte_last && (bit_cnt == 5'h07) && !frame_crc_en);

  assign frame_skip_active = frame_skip & first_byte;

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      shreg <= 16'h0000;
      bit_cnt <= 5'h00;
      crc <= 16'h0000;
      first_byte <= 1'b0;
      byte_last <= 1'b0;
      frame_crc_en <= 1'b0;
      frame_inv <= 1'b0;
      frame_type5 <= 1'b0;
      frame_skip <= 1'b0;
    end else if (CE) begin
      case (state)
        ST_IDLE: begin
          if (fifo_valid) begin
            // Settings are frozen per frame; changes apply to the next one
            crc <= start_value;
            first_byte <= 1'b1;
            frame_crc_en <= crc_enable;
            frame_inv <= crc_invert_output;
            frame_type5 <= crc_type5;
            frame_skip <= crc_skip_first_byte;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Waits here with the bit stream idle while the next byte is late
          if (fifo_valid) begin
            shreg <= {8'h00, fifo_out[7:0]};
            byte_last <= fifo_out[8];
            bit_cnt <= 5'h00;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bit_take) begin
            crc <= crc_next;
            shreg <= {1'b0, shreg[15:1]};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h07) begin
              first_byte <= 1'b0;
              bit_cnt <= 5'h00;
              if (!byte_last) begin
                state <= ST_LOAD;
              end else if (frame_crc_en) begin
                shreg <= crc_out;
                state <= ST_CRC;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_CRC: begin
          if (bit_take) begin
            shreg <= {1'b0, shreg[15:1]};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == crc_len - 5'h01) begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: rtl/tx_crc_cfg_regs.vh
// Register offsets, field positions, reset values and constants of the checksum block
`ifndef TX_CRC_CFG_REGS_VH
`define TX_CRC_CFG_REGS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define IDX_TX_CHECKSUM_CONTROL 8'h19
`define IDX_RX_SIGPRO_SETUP 8'h1A
`define IDX_DETECTOR_CONTROL 8'h30
`define ADDR_TX_CHECKSUM_CONTROL 10'h064
`define ADDR_RX_SIGPRO_SETUP 10'h068
`define ADDR_DETECTOR_CONTROL 10'h0C0

// ----------------------------------------
// Checksum control fields
// ----------------------------------------
`define CRC_SEED_HI 31
`define CRC_SEED_LO 16
`define CRC_SKIP_BIT 6
`define CRC_SEL_HI 5
`define CRC_SEL_LO 3
`define CRC_TYPE_BIT 2
`define CRC_INV_BIT 1
`define CRC_EN_BIT 0

// ----------------------------------------
// Seed codes and fixed seeds
// ----------------------------------------
`define SEED_SEL_0000 3'h0
`define SEED_SEL_6363 3'h1
`define SEED_SEL_A671 3'h2
`define SEED_SEL_FFFF 3'h3
`define SEED_SEL_0012 3'h4
`define SEED_SEL_E012 3'h5
`define SEED_SEL_RSVD 3'h6
`define SEED_SEL_CUSTOM 3'h7
`define SEED_0 16'h0000
`define SEED_1 16'h6363
`define SEED_2 16'hA671
`define SEED_3 16'hFFFF
`define SEED_4 16'h0012
`define SEED_5 16'hE012

// ----------------------------------------
// Polynomials, shifted out least significant bit first
// ----------------------------------------
`define POLY16_REFL 16'h8408
`define POLY5_REFL 5'h12
`define CRC16_LEN 5'h10
`define CRC5_LEN 5'h05

// ----------------------------------------
// Receive rate codes and own control fields
// ----------------------------------------
`define RATE_HI 2
`define RATE_LO 0
`define RATE_RESET 3'h0
`define RATE_106 3'h4
`define RATE_212 3'h5
`define RATE_424 3'h6
`define RATE_848 3'h7
`define DET_TYPE_AB 2'h0
`define DET_F212 2'h1
`define DET_F424 2'h2
`define DETCTL_AUTO_BIT 0
`define DETCTL_READER_BIT 1
`define DETCTL_BUSY_BIT 2

`endif

// File: verif/crc_bit_sink.sv
// Serial bit sink standing for the remote receiver of the transmit stream
`timescale 1ns/100ps
`default_nettype none
module crc_bit_sink (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bit_in,
  input wire logic bit_valid,
  input wire logic bit_last,
  input wire logic stall,
  input wire logic slow,
  input wire logic clr,
  output logic bit_ready,
  output logic [127:0] bits,
  output logic [7:0] n,
  output logic [7:0] last_at,
  output logic done
);
  logic phase;
  // Registered ready: the sink never reacts within the cycle it is offered a bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 1'b0;
      bit_ready <= 1'b0;
      bits <= 128'h0;
      n <= 8'h00;
      last_at <= 8'h00;
      done <= 1'b0;
    end else begin
      phase <= ~phase;
      bit_ready <= !stall && !(slow && phase);
      if (clr) begin
        bits <= 128'h0;
        n <= 8'h00;
        done <= 1'b0;
      end else if (bit_valid && bit_ready) begin
        bits[n] <= bit_in;
        n <= n + 8'h01;
        if (bit_last) last_at <= n;
        if (bit_last) done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/tx_crc_and_rx_rate_config_assertions.sv
// Checker of the register bus and serial stream of the checksum block
`timescale 1ns/100ps
`default_nettype none
module tx_crc_and_rx_rate_config_assertions (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TX_BIT,
  input wire logic TX_BIT_VALID,
  input wire logic TX_BIT_LAST,
  input wire logic TX_BIT_READY
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // ----
  // Bus
  // ----
  a_write_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && CE
    |=> !S_AXI_AWREADY ##1 S_AXI_BVALID) else $error("write answer off");
  a_bvalid_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
  a_bvalid_clear: assert property (
    S_AXI_BVALID && S_AXI_BREADY && CE |=> !S_AXI_BVALID) else $error("bvalid stuck");
  a_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && CE |=> S_AXI_RVALID) else $error("read answer late");
  a_read_block: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while busy");
  a_rvalid_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID) else $error("rvalid dropped");
  // ----
  // Serial stream
  // ----
  a_bit_hold: assert property (
    TX_BIT_VALID && !TX_BIT_READY |=> TX_BIT_VALID && $stable(TX_BIT) && $stable(TX_BIT_LAST))
    else $error("offered bit changed");
  a_last_valid: assert property (
    TX_BIT_LAST |-> TX_BIT_VALID) else $error("last without valid");
  a_last_ends: assert property (
    TX_BIT_VALID && TX_BIT_LAST && TX_BIT_READY && CE |=> !TX_BIT_VALID)
    else $error("no gap after frame");
endmodule
bind tx_crc_and_rx_rate_config tx_crc_and_rx_rate_config_assertions i_chk (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(CE),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .TX_BIT(TX_BIT), .TX_BIT_VALID(TX_BIT_VALID), .TX_BIT_LAST(TX_BIT_LAST),
  .TX_BIT_READY(TX_BIT_READY));
`default_nettype wire

// File: verif/tb_tx_crc_and_rx_rate_config.sv
// Self-checking bench of the checksum and receive rate block
`timescale 1ns/100ps
`default_nettype none
`include "tx_crc_cfg_regs.vh"
module tb_tx_crc_and_rx_rate_config;
  // ----
  // Signals
  // ----
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] awaddr = 10'h000;
  logic [9:0] araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_last = 1'b0, tx_valid = 1'b0, det = 1'b0, stall = 1'b0, slow = 1'b0, clr = 1'b0;
  logic [1:0] kind = 2'h0;
  logic saw_full = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, tx_ready, tx_bit, tx_bv, tx_bl, bit_ready;
  wire got_done;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] rx_rate;
  wire [127:0] got_bits;
  wire [7:0] got_n, got_last;
  logic [7:0] fb [12];
  int err_count = 0;
  int n_checks = 0;
  // Code 7 holds the custom seed that every frame writes
  localparam logic [15:0] SEEDS [8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF,
    16'h0012, 16'hE012, 16'h0000, 16'hC3A5};
  always #2.5 clk = ~clk;

  tx_crc_and_rx_rate_config i_dut (
    .SYS_CLK(clk), .RSTN(rstn), .CE(1'b1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_BIT(tx_bit), .TX_BIT_VALID(tx_bv), .TX_BIT_LAST(tx_bl), .TX_BIT_READY(bit_ready),
    .MODE_DETECTED(det), .MODE_KIND(kind), .RX_RATE(rx_rate));
  crc_bit_sink i_sink (.clk(clk), .rstn(rstn), .bit_in(tx_bit), .bit_valid(tx_bv),
    .bit_last(tx_bl), .stall(stall), .slow(slow), .clr(clr), .bit_ready(bit_ready),
    .bits(got_bits), .n(got_n), .last_at(got_last), .done(got_done));

  // ----
  // Tasks
  // ----
  task chk(input logic [127:0] g, input logic [127:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, g, e);
    end
  endtask
  // Waits end only by the watchdog; one idle edge keeps back-to-back calls apart
  task wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    do begin
      @(posedge clk);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(128'(bresp), 128'(r));
    @(posedge clk);
  endtask
  task rdc(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(128'(rdata), 128'(d));
    chk(128'(rresp), 128'(r));
    @(posedge clk);
  endtask
  task detect(input logic [1:0] m, input logic [2:0] e);
    kind <= m;
    det <= 1'b1;
    @(posedge clk);
    det <= 1'b0;
    @(posedge clk);
    chk(128'(rx_rate), 128'(e));
  endtask
  task push(input logic [7:0] d, input logic l);
    int k;
    k = 0;
    tx_data <= d;
    tx_last <= l;
    tx_valid <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (!tx_ready) saw_full = 1'b1;
    end while (tx_ready !== 1'b1 && k < 200);
  endtask
  function automatic logic [15:0] step(input logic [15:0] c, input logic b, input logic t);
    logic fbk;
    fbk = c[0] ^ b;
    c = c >> 1;
    if (fbk) c = c ^ (t ? 16'h0012 : 16'h8408);
    return c;
  endfunction
  task frame(input logic [2:0] sel, input logic typ, input logic inv, input logic skp,
             input logic en, input int nb);
    logic [127:0] e;
    logic [15:0] c;
    int ne;
    int k;
    wr(`ADDR_TX_CHECKSUM_CONTROL, {16'hC3A5, 9'h000, skp, sel, typ, inv, en}, 2'h0);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    // Without checksum, late bytes make the encoder wait between bytes
    for (int i = 0; i < nb; i++) begin
      push(fb[i], i == nb - 1);
      if (!en && i < nb - 1) begin
        tx_valid <= 1'b0;
        repeat (20) @(posedge clk);
      end
    end
    tx_valid <= 1'b0;
    c = typ ? {11'h000, SEEDS[sel][4:0]} : SEEDS[sel];
    ne = 0;
    e = 128'h0;
    for (int i = 0; i < nb; i++) begin
      for (int j = 0; j < 8; j++) begin
        e[ne] = fb[i][j];
        ne++;
        if (!(skp && i == 0)) c = step(c, fb[i][j], typ);
      end
    end
    for (int j = 0; j < (typ ? 5 : 16); j++) begin
      if (en) e[ne] = c[j] ^ inv;
      if (en) ne++;
    end
    k = 0;
    while (got_done !== 1'b1 && k < 600) begin
      @(posedge clk);
      k++;
    end
    chk(got_bits, e);
    chk(128'(got_n), 128'(ne));
    chk(128'(got_last), 128'(ne - 1));
  endtask
  task test_done;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // Tests
  // ----
  // Whole run needs about a thousand cycles; the 20000-cycle limit leaves wide margin
  initial begin
    #100000;
    err_count++;
    test_done;
  end
  initial begin
    for (int i = 0; i < 12; i++) fb[i] = 8'h5A ^ 8'(i * 29);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(`ADDR_TX_CHECKSUM_CONTROL, 32'h0, 2'h0);
    rdc(`ADDR_RX_SIGPRO_SETUP, 32'h0, 2'h0);
    chk(128'(rx_rate), 128'(3'h4));
    $display("test reset done");
    wr(`ADDR_TX_CHECKSUM_CONTROL, 32'hFFFF_FFFF, 2'h0);
    rdc(`ADDR_TX_CHECKSUM_CONTROL, 32'hFFFF_007F, 2'h0);
    wr(10'h010, 32'h1, 2'h2);
    rdc(10'h010, 32'h0, 2'h2);
    $display("test registers done");
    wr(`ADDR_RX_SIGPRO_SETUP, 32'h5, 2'h0);
    chk(128'(rx_rate), 128'(3'h5));
    wr(`ADDR_RX_SIGPRO_SETUP, 32'h3, 2'h0);
    chk(128'(rx_rate), 128'(3'h7));
    wr(`ADDR_DETECTOR_CONTROL, 32'h2, 2'h0);
    chk(128'(rx_rate), 128'(3'h3));
    detect(2'h1, 3'h3);
    wr(`ADDR_DETECTOR_CONTROL, 32'h3, 2'h0);
    detect(2'h0, 3'h4);
    detect(2'h1, 3'h5);
    detect(2'h2, 3'h6);
    detect(2'h3, 3'h6);
    rdc(`ADDR_RX_SIGPRO_SETUP, 32'h6, 2'h0);
    $display("test rate done");
    for (int s = 0; s < 8; s++) begin
      slow <= s[0];
      if (s != 6) frame(3'(s), s[0], s[1], s[2], 1'b1, 3);
    end
    slow <= 1'b0;
    frame(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 2);
    $display("test frames done");
    // Stalled sink backs up the FIFO until it refuses
    stall <= 1'b1;
    fork
      frame(3'h3, 1'b0, 1'b1, 1'b0, 1'b1, 12);
      begin
        repeat (60) @(posedge clk);
        stall <= 1'b0;
      end
    join
    chk(128'(saw_full), 128'(1'b1));
    $display("test fill done");
    test_done;
  end
endmodule
`default_nettype wire
